// ---- common/osd_pkg.sv ----
`default_nettype none
package osd_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 40;
  // vsync edges up to this long after an hsync edge count as bounce
  localparam int SYNC_GUARD_NS = 400;
  localparam int SYNC_GUARD_CYC = (SYNC_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SYNC_GUARD_CNT = 4'(SYNC_GUARD_CYC);

  // ************************************************************
  // register columns of the last row
  // ************************************************************
  localparam logic [5:0] COL_LINE_WIDTH = 6'h0F;
  localparam logic [5:0] COL_CONTROL = 6'h11;
  localparam logic [5:0] COL_CONFIG = 6'h12;
  localparam logic [5:0] COL_LEVEL_FIRST = 6'h13;
  localparam logic [5:0] COL_LEVEL_LAST = 6'h1A;

  // ************************************************************
  // reset values and field positions
  // ************************************************************
  localparam logic [6:0] LINE_WIDTH_RST = 7'h28;
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] CONFIG_RST = 8'h40;
  localparam logic [7:0] LEVEL_RST = 8'h00;
  localparam int CTL_SCOPE_BIT = 0;
  localparam int CTL_FORCE_BLANK_BIT = 3;
  localparam int CTL_OSD_EN_BIT = 7;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int DAC_CHANNELS = 8;
  localparam logic [7:0] PWM_LAST = 8'hFF;
  localparam logic [4:0] TOGGLES_PER_UNIT = 5'h18; // two edges per pixel of 12
  localparam logic [15:0] PERIOD_MAX = 16'hFFFF;

  // ************************************************************
  // types
  // ************************************************************
  typedef struct packed {
    logic test_mode;
    logic blank_polarity_sel;
    logic dac_clock_option;
    logic sync_edge_detect_en;
    logic hsync_polarity;
    logic vsync_polarity;
    logic pll_range_hi;
    logic pll_range_lo;
  } osd_cfg_t;

  typedef struct packed {
    logic char_dot;
    logic border_dot;
    logic win_on;
    logic [2:0] win_rgb;
    logic [2:0] char_rgb;
  } osd_pixel_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] col;
    logic [7:0] wdata;
  } osd_reg_req_t;
endpackage
`default_nettype wire

// ---- rtl/osd_pwm_chan.sv ----
`default_nettype none
module osd_pwm_chan (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // level and shared period counter
  input wire logic [7:0] level,
  input wire logic [7:0] count,
  input wire logic tick,
  // open-drain enable, high pulls low
  output logic pull_low
);
  import osd_pkg::*;

  logic [7:0] shadow;
  wire period_end = tick && (count == PWM_LAST);

  // ************************************************************
  // shadow level and output
  // ************************************************************
  // load at boundary
  // new level waits for the wrap so no runt pulse appears
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      shadow <= LEVEL_RST;
    end else if (period_end) begin
      shadow <= level;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pull_low <= 1'b1;
    end else begin
      pull_low <= !(count < shadow);
    end
  end
endmodule // osd_pwm_chan
`default_nettype wire

// ---- rtl/osd_sync_config_pwm_dac.sv ----
`default_nettype none
// How it works
// - scope bit 0 blanks on characters or windows, 1 on characters only.
// - config top bit selects test mode; software keeps it zero; here the bit is only stored.
// - blank polarity bit 1 drives high-active, 0 low-active; resets to 1.
// - shared pin gives half-tone at 0, flyback-locked square clock at 1.
// - output clock is flyback times width times 12, 6, 3 or 3/2.
// - PWM period spans 256 output clock cycles for every range.
// - edge-detect bit enables sync bounce handling; resets to 0.
// - hsync polarity bit 1 means active high, 0 active low.
// - vsync polarity bit 1 means active high, 0 active low.
// - pixel rate is flyback times width times 12; range resets to 00.
// - each output has an 8-bit width from 0/256 to 255/256.
// - level columns 19 to 26 drive outputs zero to seven.
// - all eight outputs are open drain: pull low or release.
// - video mixes window colour, border, dots and character colour.
// - width register gives pixels per line as value times 12; resets 40.
// - forced blank bit drives the blank pin high.
module osd_sync_config_pwm_dac (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // register port of the last row
  input wire osd_pkg::osd_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // timing and sync inputs
  input wire logic horiz_flyback_in,
  input wire logic hsync_in,
  input wire logic vsync_in,
  // pixel source and half-tone source
  input wire osd_pkg::osd_pixel_t pixel_in,
  input wire logic half_tone_out,
  // video and blanking
  output logic red_video_out,
  output logic green_video_out,
  output logic blue_video_out,
  output logic fast_blank_out,
  output logic tone_or_clock_out,
  // open-drain converter outputs
  output logic [7:0] dac_outputs_out,
  output logic [7:0] dac_outputs_oe,
  // normalised syncs
  output logic hsync_active,
  output logic vsync_active,
  output logic sync_distortion
);
  import osd_pkg::*;

  // ************************************************************
  // registers
  // ************************************************************
  logic [6:0] line_width_units;
  logic [7:0] control;
  logic [7:0] config_reg;
  logic [7:0] dac_level_regs [DAC_CHANNELS];
  osd_cfg_t cfg;

  assign cfg = osd_cfg_t'(config_reg);

  // address decode
  wire sel_width = reg_req.col == COL_LINE_WIDTH;
  wire sel_control = reg_req.col == COL_CONTROL;
  wire sel_config = reg_req.col == COL_CONFIG;
  wire sel_level = (reg_req.col >= COL_LEVEL_FIRST) && (reg_req.col <= COL_LEVEL_LAST);
  wire [2:0] level_idx = 3'(reg_req.col - COL_LEVEL_FIRST);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      line_width_units <= LINE_WIDTH_RST;
    end else if (reg_req.wr && sel_width) begin
      line_width_units <= reg_req.wdata[6:0];
    end
  end

  // control byte, bits beyond blanking are kept for the display core
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      control <= CONTROL_RST;
    end else if (reg_req.wr && sel_control) begin
      control <= reg_req.wdata;
    end
  end

  // test bit only stored
  // the test bit has no function here, so a stray set is harmless
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      config_reg <= CONFIG_RST;
    end else if (reg_req.wr && sel_config) begin
      config_reg <= reg_req.wdata;
    end
  end

  // level registers, one per channel
  genvar gi;
  generate
    for (gi = 0; gi < DAC_CHANNELS; gi++) begin : g_level
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          dac_level_regs[gi] <= LEVEL_RST;
        end else if (reg_req.wr && sel_level && (level_idx == 3'(gi))) begin
          dac_level_regs[gi] <= reg_req.wdata;
        end
      end
    end
  endgenerate

  // read mux; unmapped columns read as zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (sel_width) begin
      rd_mux = {1'b0, line_width_units};
    end else if (sel_control) begin
      rd_mux = control;
    end else if (sel_config) begin
      rd_mux = config_reg;
    end else if (sel_level) begin
      rd_mux = dac_level_regs[level_idx];
    end
  end

  // read data registered, held between reads
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      reg_rdata <= rd_mux;
    end
  end

  // ************************************************************
  // line period measurement
  // ************************************************************
  logic flyback_d;
  logic [15:0] line_count;
  logic [15:0] line_period;
  wire flyback_rise = horiz_flyback_in && !flyback_d;

  // period in system clocks between flyback rising edges
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      flyback_d <= 1'b0;
      line_count <= 16'h0000;
      line_period <= 16'h0000;
    end else begin
      flyback_d <= horiz_flyback_in;
      if (flyback_rise) begin
        line_count <= 16'h0000;
        line_period <= (line_count == PERIOD_MAX) ? PERIOD_MAX : line_count + 16'h0001;
      end else if (line_count != PERIOD_MAX) begin
        line_count <= line_count + 16'h0001;
      end
    end
  end

  // ************************************************************
  // output clock synthesis
  // ************************************************************
  // pixel rate source
  // range divides rate
  // edges per line = width * 24 >> range; 3/2 divides exactly at /8
  wire [1:0] range = {cfg.pll_range_hi, cfg.pll_range_lo};
  wire [11:0] step_full = 12'(line_width_units * TOGGLES_PER_UNIT);
  wire [11:0] step = step_full >> range;
  logic [15:0] phase_acc;
  logic dac_clk;
  logic dac_tick;
  wire [16:0] acc_sum = {1'b0, phase_acc} + {5'h00, step};
  wire edge_due = (line_period != 16'h0000) && (acc_sum >= {1'b0, line_period});
  wire [16:0] acc_rem = acc_sum - {1'b0, line_period};
  // one edge per system clock at most; rates beyond that saturate
  wire [15:0] next_phase_acc = !edge_due ? acc_sum[15:0] :
                               (acc_rem >= {1'b0, line_period}) ? 16'h0000 : acc_rem[15:0];

  // flyback locked clock
  // the flyback edge realigns phase so the clock stays line synchronous
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phase_acc <= 16'h0000;
      dac_clk <= 1'b0;
      dac_tick <= 1'b0;
    end else if (flyback_rise) begin
      phase_acc <= 16'h0000;
      dac_clk <= 1'b0;
      dac_tick <= 1'b0;
    end else begin
      phase_acc <= next_phase_acc;
      dac_clk <= dac_clk ^ edge_due;
      dac_tick <= edge_due && !dac_clk;
    end
  end

  // ************************************************************
  // converter period counter and channels
  // ************************************************************
  logic [7:0] pwm_count;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pwm_count <= 8'h00;
    end else if (dac_tick) begin
      pwm_count <= pwm_count + 8'h01;
    end
  end

  generate
    for (gi = 0; gi < DAC_CHANNELS; gi++) begin : g_chan
      osd_pwm_chan u_chan (
        .clock(clock),
        .resetn(resetn),
        .level(dac_level_regs[gi]),
        .count(pwm_count),
        .tick(dac_tick),
        .pull_low(dac_outputs_oe[gi])
      );
    end
  endgenerate

  // open-drain low only
  // the data side is always low; only the enable moves
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dac_outputs_out <= 8'h00;
    end else begin
      dac_outputs_out <= 8'h00;
    end
  end

  // ************************************************************
  // sync inputs
  // ************************************************************
  osd_sync_in u_sync (
    .clock(clock),
    .resetn(resetn),
    .hsync_in(hsync_in),
    .vsync_in(vsync_in),
    .hsync_polarity(cfg.hsync_polarity),
    .vsync_polarity(cfg.vsync_polarity),
    .sync_edge_detect_en(cfg.sync_edge_detect_en),
    .hsync_active(hsync_active),
    .vsync_active(vsync_active),
    .sync_distortion(sync_distortion)
  );

  // ************************************************************
  // colour encoder and blanking
  // ************************************************************
  wire osd_on = control[CTL_OSD_EN_BIT];
  wire char_shown = osd_on && (pixel_in.char_dot || pixel_in.border_dot);
  wire win_shown = osd_on && pixel_in.win_on;
  wire blank_scope_sel = control[CTL_SCOPE_BIT];
  wire blank_show = blank_scope_sel ? char_shown : (char_shown || win_shown);
  wire blank_level = cfg.blank_polarity_sel ? blank_show : !blank_show;
  wire next_fast_blank = control[CTL_FORCE_BLANK_BIT] ? 1'b1 : blank_level;

  // colour priority
  // border blackedge beats the dot, the dot beats the window
  logic [2:0] next_rgb;
  always_comb begin
    next_rgb = 3'h0;
    if (!osd_on || pixel_in.border_dot) begin
      next_rgb = 3'h0;
    end else if (pixel_in.char_dot) begin
      next_rgb = pixel_in.char_rgb;
    end else if (pixel_in.win_on) begin
      next_rgb = pixel_in.win_rgb;
    end
  end

  wire next_shared = cfg.dac_clock_option ? dac_clk : half_tone_out;

  // pin flops
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      red_video_out <= 1'b0;
      green_video_out <= 1'b0;
      blue_video_out <= 1'b0;
      fast_blank_out <= 1'b0;
      tone_or_clock_out <= 1'b0;
    end else begin
      {red_video_out, green_video_out, blue_video_out} <= next_rgb;
      fast_blank_out <= next_fast_blank;
      tone_or_clock_out <= next_shared;
    end
  end
endmodule // osd_sync_config_pwm_dac
`default_nettype wire

// ---- rtl/osd_sync_in.sv ----
`default_nettype none
module osd_sync_in (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // raw sync pins and settings
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire logic hsync_polarity,
  input wire logic vsync_polarity,
  input wire logic sync_edge_detect_en,
  // normalised syncs, high while active
  output logic hsync_active,
  output logic vsync_active,
  output logic sync_distortion
);
  import osd_pkg::*;

  logic [3:0] guard;
  wire h_now = hsync_polarity ? hsync_in : !hsync_in;
  wire v_now = vsync_polarity ? vsync_in : !vsync_in;
  wire h_edge = h_now != hsync_active;
  wire v_change = v_now != vsync_active;
  wire in_guard = sync_edge_detect_en && ((guard != 4'h0) || h_edge);

  // ************************************************************
  // guard window after each hsync edge
  // ************************************************************
  // bounce detection
  // a vsync edge in the window is held back until it closes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      guard <= 4'h0;
    end else if (h_edge) begin
      guard <= SYNC_GUARD_CNT;
    end else if (guard != 4'h0) begin
      guard <= guard - 4'h1;
    end
  end

  // syncs, and a flag for every cycle that a vsync edge is held back
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      hsync_active <= 1'b0;
      vsync_active <= 1'b0;
      sync_distortion <= 1'b0;
    end else begin
      hsync_active <= h_now;
      if (!in_guard) begin
        vsync_active <= v_now;
      end
      sync_distortion <= v_change && in_guard;
    end
  end
endmodule // osd_sync_in
`default_nettype wire

// ---- tb/osd_monitor_model.sv ----
`default_nettype none
// ********
// monitor side: flyback source and pull-ups
// ********
module osd_monitor_model #(
  parameter int LINE_CYCLES = 1000
) (
  // clock
  input wire logic clock,
  // flyback and converter pins
  output logic horiz_flyback_in,
  input wire logic [7:0] dac_outputs_oe,
  output logic [7:0] dac_lines
);
  timeunit 1ns;
  timeprecision 1ns;
  int phase = 0;
  // four-cycle flyback pulse each line, moved off the sampling edge
  always @(negedge clock) begin
    phase = (phase + 1 >= LINE_CYCLES) ? 0 : phase + 1;
    horiz_flyback_in = (phase < 4);
  end
  // external pull-up
  // a released line rises to the supply rather than keeping its last level
  assign dac_lines = ~dac_outputs_oe;
endmodule // osd_monitor_model
`default_nettype wire

// ---- tb/osd_sync_cfg_chk.sv ----
`default_nettype none
// ********
// port checks
// ********
module osd_sync_cfg_chk (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // register port and sources
  input wire osd_pkg::osd_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic horiz_flyback_in,
  input wire logic hsync_in,
  input wire logic vsync_in,
  input wire osd_pkg::osd_pixel_t pixel_in,
  input wire logic half_tone_out,
  // pins
  input wire logic red_video_out,
  input wire logic green_video_out,
  input wire logic blue_video_out,
  input wire logic fast_blank_out,
  input wire logic tone_or_clock_out,
  input wire logic [7:0] dac_outputs_out,
  input wire logic [7:0] dac_outputs_oe,
  input wire logic hsync_active,
  input wire logic vsync_active,
  input wire logic sync_distortion
);
  timeunit 1ns;
  timeprecision 1ns;
  import osd_pkg::*;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // mirror of the registers, so expectations follow every write
  logic [7:0] shadow [64];
  osd_cfg_t cfg;
  logic [7:0] ctl;
  wire logic mapped = (reg_req.col == COL_LINE_WIDTH) ||
    (reg_req.col >= COL_CONTROL && reg_req.col <= COL_LEVEL_LAST);
  wire logic [7:0] rd_exp = shadow[reg_req.col];
  wire logic en_live = ctl[CTL_OSD_EN_BIT] & ~ctl[CTL_FORCE_BLANK_BIT];
  wire logic char_live = ctl[CTL_OSD_EN_BIT] & pixel_in.char_dot;
  wire logic blank_act = pixel_in.char_dot | pixel_in.border_dot |
    (~ctl[CTL_SCOPE_BIT] & pixel_in.win_on);
  assign cfg = osd_cfg_t'(shadow[COL_CONFIG]);
  assign ctl = shadow[COL_CONTROL];
  // width keeps seven bits, so the top bit reads zero
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 64; i++) shadow[i] <= 8'h00;
      shadow[COL_LINE_WIDTH] <= 8'h28;
      shadow[COL_CONFIG] <= 8'h40;
    end else if (reg_req.wr && mapped) begin
      shadow[reg_req.col] <= (reg_req.col == COL_LINE_WIDTH) ? {1'b0, reg_req.wdata[6:0]}
        : reg_req.wdata;
    end
  end
  read_back_a: assert property (reg_req.rd |=> reg_rdata == $past(rd_exp))
    else $error("read data differs from mirror");
  hsync_pol_a: assert property ($past(resetn) |->
    hsync_active == ($past(hsync_in) == $past(cfg.hsync_polarity)))
    else $error("hsync active level wrong");
  vsync_pol_a: assert property ($past(resetn) && !$past(cfg.sync_edge_detect_en) |->
    vsync_active == ($past(vsync_in) == $past(cfg.vsync_polarity)))
    else $error("vsync active level wrong");
  forced_blank_a: assert property ($past(resetn) && $past(ctl[CTL_FORCE_BLANK_BIT]) |->
    fast_blank_out)
    else $error("forced blank not high");
  blank_scope_a: assert property ($past(resetn) && $past(en_live) |->
    fast_blank_out == ($past(blank_act) == $past(cfg.blank_polarity_sel)))
    else $error("blank level wrong");
  char_colour_a: assert property ($past(resetn) && $past(char_live) |->
    {red_video_out, green_video_out, blue_video_out} == $past(pixel_in.char_rgb))
    else $error("character colour wrong");
  open_drain_a: assert property (dac_outputs_out == 8'h00)
    else $error("converter pin driven high");
  tone_pass_a: assert property ($past(resetn) && !$past(cfg.dac_clock_option) |->
    tone_or_clock_out == $past(half_tone_out))
    else $error("half-tone not passed");
  bounce_gate_a: assert property (sync_distortion |-> $past(cfg.sync_edge_detect_en))
    else $error("bounce flagged while disabled");
endmodule // osd_sync_cfg_chk
bind osd_sync_config_pwm_dac osd_sync_cfg_chk chk_u (
  .clock(clock), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .horiz_flyback_in(horiz_flyback_in), .hsync_in(hsync_in), .vsync_in(vsync_in),
  .pixel_in(pixel_in), .half_tone_out(half_tone_out), .red_video_out(red_video_out),
  .green_video_out(green_video_out), .blue_video_out(blue_video_out),
  .fast_blank_out(fast_blank_out), .tone_or_clock_out(tone_or_clock_out),
  .dac_outputs_out(dac_outputs_out), .dac_outputs_oe(dac_outputs_oe),
  .hsync_active(hsync_active), .vsync_active(vsync_active),
  .sync_distortion(sync_distortion)
);
`default_nettype wire

// ---- tb/tb.sv ----
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import osd_pkg::*;
  // ********
  // signals
  // ********
  logic clock = 1'b0;
  logic resetn = 1'b0;
  osd_reg_req_t reg_req = '0;
  osd_pixel_t pixel_in = '0;
  logic hsync_in = 1'b0;
  logic vsync_in = 1'b0;
  logic half_tone_out = 1'b0;
  logic horiz_flyback_in, red_video_out, green_video_out, blue_video_out;
  logic fast_blank_out, tone_or_clock_out, hsync_active, vsync_active, sync_distortion;
  logic [7:0] reg_rdata, dac_outputs_out, dac_outputs_oe, dac_lines;
  logic tone_prev = 1'b0;
  int err_count = 0;
  int comparisons = 0;
  int dist_count = 0;
  wire logic tone_rise = tone_or_clock_out & ~tone_prev;
  osd_sync_config_pwm_dac dut_u (
    .clock(clock), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .horiz_flyback_in(horiz_flyback_in), .hsync_in(hsync_in), .vsync_in(vsync_in),
    .pixel_in(pixel_in), .half_tone_out(half_tone_out), .red_video_out(red_video_out),
    .green_video_out(green_video_out), .blue_video_out(blue_video_out),
    .fast_blank_out(fast_blank_out), .tone_or_clock_out(tone_or_clock_out),
    .dac_outputs_out(dac_outputs_out), .dac_outputs_oe(dac_outputs_oe),
    .hsync_active(hsync_active), .vsync_active(vsync_active),
    .sync_distortion(sync_distortion)
  );
  osd_monitor_model mon_u (
    .clock(clock), .horiz_flyback_in(horiz_flyback_in), .dac_outputs_oe(dac_outputs_oe),
    .dac_lines(dac_lines)
  );
  always #20 clock = ~clock;
  // rising edges of the shared pin and bounce pulses, seen settled once per cycle
  always @(negedge clock) begin
    tone_prev <= tone_or_clock_out;
    if (sync_distortion === 1'b1) dist_count++;
  end
  // ********
  // shared tasks, entered at a falling edge
  // ********
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    reg_req = '0;
    repeat (n) @(negedge clock);
  endtask
  task automatic reg_wr(input logic [5:0] col, input logic [7:0] data);
    reg_req = '{1'b1, 1'b0, col, data};
    @(negedge clock);
  endtask
  task automatic reg_rd(input logic [5:0] col, input logic [7:0] exp);
    reg_req = '{1'b0, 1'b1, col, 8'h00};
    @(negedge clock);
    check("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp});
  endtask
  task automatic wait_line(input int ch, input logic val);
    int n;
    n = 0;
    while (dac_lines[ch] !== val) begin
      n++;
      if (n > 1200) begin
        err_count++;
        $display("unexpected timeout on dac line %0d", ch);
        print_verdict();
      end
      @(negedge clock);
    end
  endtask
  // one released stretch, counted in converter clock edges
  task automatic released_run(input int ch, input logic [7:0] lvl, input logic change);
    int rises;
    wait_line(ch, 1'b0);
    wait_line(ch, 1'b1);
    rises = 0;
    while (dac_lines[ch] === 1'b1 && rises < 300) begin
      rises += int'(tone_rise === 1'b1);
      reg_req = (change && rises == 10) ? '{1'b1, 1'b0, COL_LEVEL_FIRST, 8'h40} : '0;
      @(negedge clock);
    end
    check("released_edges", 16'(rises), {8'h00, lvl});
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_regs();
    reg_rd(COL_LINE_WIDTH, 8'h28);
    reg_rd(COL_CONFIG, 8'h40);
    reg_rd(6'h10, 8'h00);
    check("dac_oe", {8'h00, dac_outputs_oe}, 16'h00FF);
    // two flyback lines before level writes, so the clock has settled
    idle(2000);
    for (int i = 0; i < 8; i++) reg_wr(COL_LEVEL_FIRST + 6'(i), 8'(17 * (i + 1)));
    reg_wr(6'h1B, 8'h5A);
    reg_wr(COL_LINE_WIDTH, 8'hFF);
    for (int i = 0; i < 8; i++) reg_rd(COL_LEVEL_FIRST + 6'(i), 8'(17 * (i + 1)));
    reg_rd(COL_LINE_WIDTH, 8'h7F);
    reg_rd(6'h1B, 8'h00);
    reg_wr(COL_LINE_WIDTH, 8'h28);
  endtask
  task automatic t_blank();
    osd_pixel_t pat [3];
    pat[0] = '{1'b1, 1'b0, 1'b0, 3'h2, 3'h5};
    pat[1] = '{1'b0, 1'b0, 1'b1, 3'h6, 3'h1};
    pat[2] = '0;
    for (int n = 0; n < 12; n++) begin
      reg_wr(COL_CONTROL, {7'h40, n[0]});
      reg_wr(COL_CONFIG, {1'b0, n[1], 6'h00});
      pixel_in = pat[n / 4];
      idle(2);
      check("fast_blank", 16'(fast_blank_out),
        16'((pat[n / 4].char_dot | (~n[0] & pat[n / 4].win_on)) == n[1]));
      if (n < 4) check("video", {13'h0, red_video_out, green_video_out, blue_video_out}, 16'h5);
    end
    reg_wr(COL_CONTROL, 8'h88);
    idle(2);
    check("forced_blank", 16'(fast_blank_out), 16'h1);
  endtask
  task automatic t_sync();
    for (int n = 0; n < 16; n++) begin
      reg_wr(COL_CONFIG, {4'h4, n[0], n[1], 2'b00});
      hsync_in = n[2];
      vsync_in = n[3];
      idle(2);
      check("hsync_active", 16'(hsync_active), 16'(n[2] == n[0]));
      check("vsync_active", 16'(vsync_active), 16'(n[3] == n[1]));
    end
    hsync_in = 1'b0;
    vsync_in = 1'b0;
    reg_wr(COL_CONFIG, 8'h5C);
    idle(20);
    check("bounce_off", 16'(dist_count), 16'h0);
    hsync_in = 1'b1;
    @(negedge clock);
    vsync_in = 1'b1;
    idle(2);
    check("vsync_held", 16'(vsync_active), 16'h0);
    idle(14);
    check("vsync_late", 16'(vsync_active), 16'h1);
    check("bounce_on", 16'(dist_count), 16'(SYNC_GUARD_CYC));
  endtask
  task automatic t_clock();
    int rises;
    reg_wr(COL_CONFIG, 8'h40);
    half_tone_out = 1'b1;
    idle(2);
    check("tone", 16'(tone_or_clock_out), 16'h1);
    for (int r = 0; r < 4; r++) begin
      reg_wr(COL_CONFIG, {6'h18, 2'(r)});
      idle(3000);
      rises = 0;
      repeat (1000) begin
        @(negedge clock);
        rises += int'(tone_rise === 1'b1);
      end
      check("clock_edges", 16'(rises), 16'(480 >> r));
    end
  endtask
  task automatic t_pwm();
    int n;
    reg_wr(COL_CONFIG, 8'h60);
    idle(1500);
    reg_wr(COL_LEVEL_FIRST, 8'h80);
    reg_wr(COL_LEVEL_FIRST + 6'h03, 8'hFF);
    reg_wr(COL_LEVEL_LAST, 8'h00);
    idle(1500);
    released_run(0, 8'h80, 1'b1);
    released_run(0, 8'h40, 1'b0);
    released_run(3, 8'hFF, 1'b0);
    n = 0;
    repeat (600) begin
      @(negedge clock);
      n += int'(dac_lines[7] !== 1'b0);
    end
    check("level_zero", 16'(n), 16'h0);
  endtask
  // ********
  // main sequence
  // ********
  initial begin
    repeat (10) @(negedge clock);
    resetn = 1'b1;
    t_regs();
    t_blank();
    t_sync();
    t_clock();
    t_pwm();
    resetn = 1'b0;
    idle(2);
    check("oe_in_reset", {8'h00, dac_outputs_oe}, 16'h00FF);
    resetn = 1'b1;
    reg_rd(COL_CONFIG, 8'h40);
    print_verdict();
  end
endmodule // tb
`default_nettype wire
